// ### pkg/drive_cmd_map.vh
`ifndef DRIVE_CMD_MAP_VH
`define DRIVE_CMD_MAP_VH
// Function
// (RULE1) One command source: panel, terminals, or serial
// (RULE2) Panel run key starts, stop key stops
// (RULE3) Two-wire: single switch sets direction, else stop
// (RULE4) Three-wire: stop permit low stops at once
// (RULE5) Three-wire buttons act on edge, latest wins
// (RULE6) Terminal functions found through assignment codes
// (RULE7) Nonzero comm timeout stops drive on silence
// (RULE8) Serial slave takes commands, reports state
// (RULE9) Start mode: direct or speed tracking
// (RULE10) Tracking start waits for motor speed match
// (RULE11) Stop mode: decelerate or coast
// (RULE12) Zero timed stop duration disables timed stop
// (RULE13) Timed stop when running time reaches duration
// (RULE14) Panel jog while key held, release decelerates
// (RULE15) Direction invert reverses panel run and jog
// (RULE16) Reverse only allowed when inhibit is zero
// (RULE17) Terminal jog button toggles jog, stop decelerates
// (RULE18) Main reference offers ten modes
// (RULE19) Main, auxiliary, switch or sum form target
// (RULE20) Unselected sources ignored, source change applies next

// Command source codes
`define SRC_PANEL    2'h0
`define SRC_TERMINAL 2'h1
`define SRC_COMM     2'h2

// Switch signal modes
`define SW_TWO_WIRE   1'h0
`define SW_THREE_WIRE 1'h1

// Input terminal function codes
`define FN_WIDTH      4
`define FN_FORWARD    4'h1
`define FN_REVERSE    4'h2
`define FN_STOP_PERMIT 4'h3
`define FN_FWD_JOG    4'h4
`define FN_REV_JOG    4'h5
`define FN_FREQ_SWAP  4'h6

// Serial command codes
`define CC_FWD_RUN    3'h1
`define CC_REV_RUN    3'h2
`define CC_FWD_JOG    3'h3
`define CC_REV_JOG    3'h4
`define CC_DECEL_STOP 3'h5
`define CC_COAST_STOP 3'h6

// Start and stop modes
`define START_DIRECT  1'h0
`define START_TRACK   1'h1
`define STOP_DECEL    1'h0
`define STOP_COAST    1'h1
`define TIMED_STOP_ON 1'h1
`define REV_ALLOWED   1'h0

// Reference selection
`define REF_MODES     4'hA
`define REF_DEFAULT   4'h0
`define COMB_MAIN     2'h0
`define COMB_AUX      2'h1
`define COMB_SUM      2'h2
`define COMB_SWITCH   2'h3

// Source indicator codes
`define IND_OFF   2'h0
`define IND_ON    2'h1
`define IND_BLINK 2'h2

// Timing
`define MCLK_HZ        40000000
`define TICK_PERIOD_MS 100
`define TICKS_PER_MIN  600
`endif

// ### src/time_tick.v
`include "drive_cmd_map.vh"

module time_tick #(
  parameter TICK_CYCLES = `MCLK_HZ / 1000 * `TICK_PERIOD_MS
) (
  input  wire mclk,    // System clock
  input  wire reset_n, // Async reset, active low
  output reg  tick,    // Pulse each tick period
  output reg  blink    // Toggles each tick
);

  localparam CW = 32;

  reg [CW-1:0] count;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {CW{1'b0}};
      tick  <= 1'b0;
      blink <= 1'b0;
    end else if (count == TICK_CYCLES[CW-1:0] - 32'h1) begin
      count <= {CW{1'b0}};
      tick  <= 1'b1;
      blink <= ~blink;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// ### src/drive_run_command_select.v
`include "drive_cmd_map.vh"

module drive_run_command_select #(
  parameter TICK_CYCLES = `MCLK_HZ / 1000 * `TICK_PERIOD_MS,
  parameter TERMS       = 5,
  parameter FW          = 16
) (
  input  wire               mclk,                  // Clock
  input  wire               reset_n,               // Async reset, active low
  input  wire [1:0]         command_source_select, // Command source
  input  wire               switch_signal_mode,    // Two- or three-wire
  input  wire [TERMS*4-1:0] input_function_assign, // Code per terminal
  input  wire [TERMS-1:0]   logic_input_terminal,  // Terminal levels
  input  wire               panel_run_key,         // Run key level
  input  wire               panel_stop_key,        // Stop key level
  input  wire               multifunction_key_hold,// Jog key level
  input  wire               comm_cmd_valid,        // Command strobe
  input  wire [2:0]         comm_cmd,              // Command code
  input  wire               comm_frame_ok,         // Good frame for us
  input  wire [7:0]         comm_timeout_setting,  // Ticks, 0 off
  input  wire               start_mode_select,     // Direct or tracking
  input  wire               dc_brake_enable,       // Brake before direct start
  input  wire               dc_brake_done,         // Brake time over
  input  wire               speed_matched,         // Motor speed found
  input  wire               stop_mode_select,      // Decelerate or coast
  input  wire               output_freq_zero,      // Ramp reached zero
  input  wire [15:0]        timed_stop_duration,   // Minutes, 0 off
  input  wire               timed_stop_enable,     // Timed stop on
  input  wire               direction_invert,      // Invert panel dir
  input  wire               reverse_inhibit,       // Reverse forbidden
  input  wire [3:0]         main_ref_source_select,// Main mode
  input  wire [1:0]         ref_combine_select,    // Target formula
  input  wire [FW-1:0]      main_freq,             // Main frequency
  input  wire [FW-1:0]      aux_freq,              // Aux frequency
  output reg                drive_output_enable,   // Output on
  output reg                run_forward,           // Running forward
  output reg                run_reverse,           // Running reverse
  output reg                jog_active,            // Jog running
  output reg                dc_brake_active,       // DC brake phase
  output reg                speed_track_active,    // Tracking phase
  output reg                decel_active,          // Decelerating
  output reg                run_indicator,         // Run lamp
  output reg  [1:0]         source_indicator,      // Off, on or blink
  output reg                source_lamp,           // Source lamp
  output reg                comm_timeout_flag,     // Silence stop
  output reg                timed_stop_flag,       // Timed stop fired
  output reg                reverse_blocked,       // Reverse refused
  output reg  [3:0]         main_ref_channel,      // Active main mode
  output reg                aux_selected,          // Target is aux alone
  output reg  [FW-1:0]      target_freq            // Target frequency
);

  localparam ST_STOP  = 3'h0;
  localparam ST_DCB   = 3'h1;
  localparam ST_TRACK = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_DECEL = 3'h4;

  // OR of all terminals carrying the given function
  function term_fn;
    input [TERMS*4-1:0] assign_codes;
    input [TERMS-1:0]   levels;
    input [3:0]         fn;
    integer i;
    begin
      term_fn = 1'b0;
      for (i = 0; i < TERMS; i = i + 1)
        if (assign_codes[i*4 +: 4] == fn && levels[i])
          term_fn = 1'b1;
    end
  endfunction

  wire tick;
  wire blink;

  time_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tick    (tick),
    .blink   (blink)
  );

  wire t_fwd    = term_fn(input_function_assign, logic_input_terminal, `FN_FORWARD); // [RULE6]
  wire t_rev    = term_fn(input_function_assign, logic_input_terminal, `FN_REVERSE);
  wire t_permit = term_fn(input_function_assign, logic_input_terminal, `FN_STOP_PERMIT);
  wire t_forward_jog_button   = term_fn(input_function_assign, logic_input_terminal, `FN_FWD_JOG);
  wire t_reverse_jog_button   = term_fn(input_function_assign, logic_input_terminal, `FN_REV_JOG);
  wire t_swap   = term_fn(input_function_assign, logic_input_terminal, `FN_FREQ_SWAP);

  reg        prev_run_key;
  reg        prev_stop_key;
  reg        prev_fwd;
  reg        prev_rev;
  reg        prev_forward_jog_button;
  reg        prev_reverse_jog_button;
  reg [1:0]  prev_source;
  reg        panel_run;
  reg        tw3_run;
  reg        tw3_dir;
  reg        tjog_run;
  reg        tjog_dir;
  reg        comm_run;
  reg        comm_dir;
  reg        comm_jog;
  reg        comm_coast;
  reg        halt;
  reg [2:0]  state;
  reg        cur_dir;
  reg        cur_jog;
  reg [7:0]  silence;
  reg [9:0]  min_ticks;
  reg [15:0] run_minutes;

  wire is_panel = (command_source_select == `SRC_PANEL);
  wire is_term  = (command_source_select == `SRC_TERMINAL);
  wire is_comm  = (command_source_select == `SRC_COMM);
  wire src_chg  = (command_source_select != prev_source);
  wire stopped  = (state == ST_STOP);

  wire run_press  = panel_run_key & ~prev_run_key;
  wire stop_press = panel_stop_key & ~prev_stop_key;
  wire fwd_press  = t_fwd & ~prev_fwd;
  wire rev_press  = t_rev & ~prev_rev;
  wire forward_jog_button_press = t_forward_jog_button & ~prev_forward_jog_button;
  wire reverse_jog_button_press = t_reverse_jog_button & ~prev_reverse_jog_button;

  // Auto stops
  wire comm_expire = is_comm && comm_timeout_setting != 8'h0 &&
                     silence >= comm_timeout_setting && !stopped;                // [RULE7]
  wire timed_on    = timed_stop_enable == `TIMED_STOP_ON &&
                     timed_stop_duration != 16'h0;                                // [RULE12]
  wire timed_expire = timed_on && run_minutes >= timed_stop_duration && !stopped; // [RULE13]
  wire force_stop  = comm_expire | timed_expire;

  reg raw_run;
  reg raw_dir;
  reg raw_jog;
  reg raw_coast;

  // Only the selected source is heard
  always @* begin
    raw_run   = 1'b0;
    raw_dir   = 1'b0;
    raw_jog   = 1'b0;
    raw_coast = 1'b0;
    case (command_source_select)                                       // [RULE1] [RULE20]
      `SRC_PANEL: begin
        if (panel_run) begin
          raw_run = 1'b1;                                               // [RULE2]
          raw_dir = direction_invert;                                   // [RULE15]
        end else if (multifunction_key_hold && (stopped || cur_jog)) begin
          raw_run = 1'b1;                                               // [RULE14]
          raw_jog = 1'b1;
          raw_dir = direction_invert;                                   // [RULE15]
        end
        // Jog release always ramps down
        raw_coast = ~panel_run & stop_mode_select & ~multifunction_key_hold;
      end
      `SRC_TERMINAL: begin
        if (tjog_run) begin
          raw_run = 1'b1;                                               // [RULE17]
          raw_jog = 1'b1;
          raw_dir = tjog_dir;
        end else if (switch_signal_mode == `SW_TWO_WIRE) begin
          raw_run = t_fwd ^ t_rev;                                      // [RULE3]
          raw_dir = t_rev & ~t_fwd;
          raw_coast = stop_mode_select;
        end else begin
          raw_run = tw3_run & t_permit;                                 // [RULE4]
          raw_dir = tw3_dir;
          raw_coast = stop_mode_select;
        end
      end
      `SRC_COMM: begin
        raw_run   = comm_run;                                           // [RULE8]
        raw_dir   = comm_dir;
        raw_jog   = comm_jog;
        raw_coast = comm_coast;
      end
      default: raw_run = 1'b0;
    endcase
  end

  wire rev_refused = raw_run && raw_dir && reverse_inhibit != `REV_ALLOWED; // [RULE16]
  wire run_req     = raw_run && !rev_refused && !halt && !force_stop;
  wire coast_req   = force_stop ? (stop_mode_select == `STOP_COAST) :
                     (raw_coast && !cur_jog);                              // [RULE11]

  reg [2:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      ST_STOP: begin
        if (run_req) begin
          if (start_mode_select == `START_TRACK)
            next_state = ST_TRACK;                                      // [RULE9]
          else if (dc_brake_enable)
            next_state = ST_DCB;                                        // [RULE9]
          else
            next_state = ST_RUN;
        end
      end
      ST_DCB: begin
        if (!run_req)
          next_state = ST_STOP;
        else if (dc_brake_done)
          next_state = ST_RUN;
      end
      ST_TRACK: begin
        if (!run_req)
          next_state = ST_STOP;
        else if (speed_matched)
          next_state = ST_RUN;                                          // [RULE10]
      end
      ST_RUN: begin
        if (!run_req)
          next_state = coast_req ? ST_STOP : ST_DECEL;                  // [RULE11]
      end
      ST_DECEL: begin
        if (run_req)
          next_state = ST_RUN;
        else if (output_freq_zero)
          next_state = ST_STOP;
      end
      default: next_state = ST_STOP;
    endcase
  end

  // Command latches of the sources
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_run_key  <= 1'b0;
      prev_stop_key <= 1'b0;
      prev_fwd      <= 1'b0;
      prev_rev      <= 1'b0;
      prev_forward_jog_button     <= 1'b0;
      prev_reverse_jog_button     <= 1'b0;
      prev_source   <= `SRC_PANEL;
      panel_run     <= 1'b0;
      tw3_run       <= 1'b0;
      tw3_dir       <= 1'b0;
      tjog_run      <= 1'b0;
      tjog_dir      <= 1'b0;
      comm_run      <= 1'b0;
      comm_dir      <= 1'b0;
      comm_jog      <= 1'b0;
      comm_coast    <= 1'b0;
      halt          <= 1'b0;
    end else begin
      prev_run_key  <= panel_run_key;
      prev_stop_key <= panel_stop_key;
      prev_fwd      <= t_fwd;
      prev_rev      <= t_rev;
      prev_forward_jog_button     <= t_forward_jog_button;
      prev_reverse_jog_button     <= t_reverse_jog_button;
      prev_source   <= command_source_select;
      // A source change drops every latched command
      if (src_chg || force_stop) begin                                  // [RULE20]
        panel_run <= 1'b0;
        tw3_run   <= 1'b0;
        tjog_run  <= 1'b0;
        comm_run  <= 1'b0;
        comm_jog  <= 1'b0;
      end else begin
        if (is_panel) begin
          if (stop_press)
            panel_run <= 1'b0;                                          // [RULE2]
          else if (run_press)
            panel_run <= 1'b1;                                          // [RULE2]
        end
        if (is_term && switch_signal_mode == `SW_THREE_WIRE) begin
          if (!t_permit) begin
            tw3_run <= 1'b0;                                            // [RULE4]
          end else if (rev_press) begin
            tw3_run <= 1'b1;                                            // [RULE5]
            tw3_dir <= 1'b1;
          end else if (fwd_press) begin
            tw3_run <= 1'b1;                                            // [RULE5]
            tw3_dir <= 1'b0;
          end
        end
        if (is_term) begin
          if (tjog_run && ((forward_jog_button_press && !tjog_dir) || (reverse_jog_button_press && tjog_dir))) begin
            tjog_run <= 1'b0;                                           // [RULE17]
          end else if (stopped && !tjog_run && (forward_jog_button_press || reverse_jog_button_press)) begin
            tjog_run <= 1'b1;                                           // [RULE17]
            tjog_dir <= reverse_jog_button_press & ~forward_jog_button_press;
          end
        end
        if (is_comm && comm_cmd_valid) begin                            // [RULE8]
          case (comm_cmd)
            `CC_FWD_RUN, `CC_REV_RUN, `CC_FWD_JOG, `CC_REV_JOG: begin
              comm_run <= 1'b1;
              comm_dir <= (comm_cmd == `CC_REV_RUN) || (comm_cmd == `CC_REV_JOG);
              comm_jog <= (comm_cmd == `CC_FWD_JOG) || (comm_cmd == `CC_REV_JOG);
            end
            `CC_DECEL_STOP, `CC_COAST_STOP: begin
              comm_run   <= 1'b0;
              comm_jog   <= 1'b0;
              comm_coast <= (comm_cmd == `CC_COAST_STOP);
            end
            default: comm_run <= comm_run;
          endcase
        end
      end
      // After an auto stop a level request must drop before a restart
      if (force_stop)
        halt <= 1'b1;
      else if (!raw_run)
        halt <= 1'b0;
    end
  end

  // Serial silence and running time
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      silence           <= 8'h0;
      min_ticks         <= 10'h0;
      run_minutes       <= 16'h0;
      comm_timeout_flag <= 1'b0;
      timed_stop_flag   <= 1'b0;
    end else begin
      if (comm_frame_ok || !is_comm)
        silence <= 8'h0;
      else if (tick && silence != 8'hFF)
        silence <= silence + 8'h1;
      // The event outranks the clear in the same cycle
      if (comm_expire)
        comm_timeout_flag <= 1'b1;                                      // [RULE7]
      else if (comm_frame_ok)
        comm_timeout_flag <= 1'b0;
      if (stopped) begin
        min_ticks   <= 10'h0;
        run_minutes <= 16'h0;
      end else if (tick) begin
        if (min_ticks == `TICKS_PER_MIN - 1) begin
          min_ticks <= 10'h0;
          if (run_minutes != 16'hFFFF)
            run_minutes <= run_minutes + 16'h1;                         // [RULE13]
        end else begin
          min_ticks <= min_ticks + 10'h1;
        end
      end
      if (timed_expire)
        timed_stop_flag <= 1'b1;                                        // [RULE13]
      else if (run_req && stopped)
        timed_stop_flag <= 1'b0;
    end
  end

  reg [FW:0] sum;
  reg        use_aux;

  always @* begin
    sum     = {1'b0, main_freq} + {1'b0, aux_freq};
    use_aux = 1'b0;
    case (ref_combine_select)                                           // [RULE19]
      `COMB_MAIN:   use_aux = 1'b0;
      `COMB_AUX:    use_aux = 1'b1;
      `COMB_SWITCH: use_aux = t_swap;
      default:      use_aux = 1'b0;
    endcase
  end

  // State and registered outputs
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= ST_STOP;
      cur_dir             <= 1'b0;
      cur_jog             <= 1'b0;
      drive_output_enable <= 1'b0;
      run_forward         <= 1'b0;
      run_reverse         <= 1'b0;
      jog_active          <= 1'b0;
      dc_brake_active     <= 1'b0;
      speed_track_active  <= 1'b0;
      decel_active        <= 1'b0;
      run_indicator       <= 1'b0;
      source_indicator    <= `IND_OFF;
      source_lamp         <= 1'b0;
      reverse_blocked     <= 1'b0;
      main_ref_channel    <= `REF_DEFAULT;
      aux_selected        <= 1'b0;
      target_freq         <= {FW{1'b0}};
    end else begin
      state <= next_state;
      if (run_req) begin
        cur_dir <= raw_dir;
        cur_jog <= raw_jog;
      end else if (next_state == ST_STOP) begin
        cur_jog <= 1'b0;
      end
      drive_output_enable <= next_state == ST_DCB || next_state == ST_RUN ||
                             next_state == ST_DECEL;                    // [RULE10]
      run_forward  <= next_state != ST_STOP && !(run_req ? raw_dir : cur_dir);
      run_reverse  <= next_state != ST_STOP && (run_req ? raw_dir : cur_dir); // [RULE16]
      jog_active   <= next_state != ST_STOP && (run_req ? raw_jog : cur_jog);
      dc_brake_active    <= next_state == ST_DCB;
      speed_track_active <= next_state == ST_TRACK;
      decel_active       <= next_state == ST_DECEL;
      run_indicator      <= next_state != ST_STOP && next_state != ST_DECEL; // [RULE2]
      reverse_blocked    <= rev_refused;                                // [RULE16]
      case (command_source_select)
        `SRC_TERMINAL: source_indicator <= `IND_ON;
        `SRC_COMM:     source_indicator <= `IND_BLINK;
        default:       source_indicator <= `IND_OFF;
      endcase
      source_lamp <= is_term | (is_comm & blink);
      if (main_ref_source_select < `REF_MODES)                          // [RULE18]
        main_ref_channel <= main_ref_source_select;
      else
        main_ref_channel <= `REF_DEFAULT;
      aux_selected <= use_aux;
      if (ref_combine_select == `COMB_SUM)                              // [RULE19]
        target_freq <= sum[FW] ? {FW{1'b1}} : sum[FW-1:0];
      else
        target_freq <= use_aux ? aux_freq : main_freq;
    end
  end

endmodule

// ### sim/drive_plant_model.sv
module drive_plant_model #(
  parameter LAG = 4
) (
  input  wire mclk,                // Clock
  input  wire reset_n,             // Reset, active low
  input  wire drive_output_enable, // Output on
  input  wire decel_active,        // Ramping down
  input  wire dc_brake_active,     // Brake phase
  input  wire speed_track_active,  // Tracking phase
  output wire output_freq_zero,    // Ramp at zero
  output wire dc_brake_done,       // Brake over
  output wire speed_matched        // Speed found
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [3:0] ramp;
  reg [3:0] phase;
  // Zero comes a few cycles into a decel
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) ramp <= 4'h0;
    else if (decel_active) ramp <= ramp - {3'h0, ramp != 4'h0};
    else if (drive_output_enable) ramp <= LAG[3:0];
  end
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) phase <= 4'h0;
    else if (dc_brake_active || speed_track_active) phase <= phase + {3'h0, phase != 4'hF};
    else phase <= 4'h0;
  end
  assign output_freq_zero = ramp == 4'h0;
  assign dc_brake_done = phase >= LAG[3:0];
  assign speed_matched = phase >= LAG[3:0];
endmodule

// ### sim/drive_cmd_checker.sv
`include "drive_cmd_map.vh"

module drive_cmd_checker (
  input wire        mclk,                  // Clock
  input wire        reset_n,               // Reset
  input wire [1:0]  command_source_select, // Source
  input wire        panel_run_key,         // Key
  input wire        panel_stop_key,        // Key
  input wire        start_mode_select,     // Mode
  input wire        dc_brake_enable,       // Brake
  input wire        direction_invert,      // Invert
  input wire        reverse_inhibit,       // Inhibit
  input wire        timed_stop_enable,     // Timed
  input wire [15:0] timed_stop_duration,   // Minutes
  input wire [7:0]  comm_timeout_setting,  // Limit
  input wire        output_freq_zero,      // Zero
  input wire        run_forward,           // Fwd
  input wire        run_reverse,           // Rev
  input wire        run_indicator,         // Lamp
  input wire        decel_active,          // Decel
  input wire        jog_active,            // Jog
  input wire        speed_track_active,    // Track
  input wire        timed_stop_flag,       // Timed
  input wire        comm_timeout_flag      // Silence
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_reverse_gate: assert property (reverse_inhibit |-> !run_reverse)
    else $error("reverse while inhibited");
  chk_dir_excl: assert property (!(run_forward && run_reverse))
    else $error("both directions");
  chk_direct_start: assert property (!start_mode_select |-> !speed_track_active)
    else $error("tracking in direct mode");
  chk_timed_gate: assert property ($rose(timed_stop_flag) |->
    timed_stop_enable && timed_stop_duration != 16'h0000) else $error("timed stop fired");
  chk_timeout_gate: assert property ($rose(comm_timeout_flag) |->
    comm_timeout_setting != 8'h00) else $error("timeout fired");
  chk_decel_hold: assert property (decel_active && !output_freq_zero |=> decel_active)
    else $error("decel ended early");
  chk_panel_start: assert property (
    command_source_select == `SRC_PANEL && $rose(panel_run_key) && !panel_stop_key
    && !run_indicator && !decel_active && !jog_active && !direction_invert
    && !start_mode_select && !dc_brake_enable |-> ##[1:2] run_indicator && run_forward)
    else $error("run key ignored");
  chk_panel_stop: assert property (
    command_source_select == `SRC_PANEL && $rose(panel_stop_key) && run_indicator
    && !jog_active |-> ##[1:2] !run_indicator) else $error("stop key ignored");
endmodule

bind drive_run_command_select drive_cmd_checker drive_cmd_checker_i (.*);

// ### sim/drive_run_command_select_tb.sv
`include "drive_cmd_map.vh"

module drive_run_command_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam TICK = 10;
  reg         mclk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  pins = 8'h00;
  reg  [1:0]  command_source_select = 2'h0, ref_combine_select = 2'h0;
  reg  [19:0] input_function_assign = 20'h04321;
  reg  [3:0]  main_ref_source_select = 4'h0;
  reg  [2:0]  comm_cmd = 3'h0;
  reg  [7:0]  comm_timeout_setting = 8'h00;
  reg  [15:0] timed_stop_duration = 16'h0000, main_freq = 16'h0003, aux_freq = 16'h0005;
  reg         switch_signal_mode = 1'b0, comm_cmd_valid = 1'b0, comm_frame_ok = 1'b0;
  reg         start_mode_select = 1'b0, dc_brake_enable = 1'b0, stop_mode_select = 1'b0;
  reg         timed_stop_enable = 1'b0, direction_invert = 1'b0, reverse_inhibit = 1'b0;
  wire [4:0]  logic_input_terminal = pins[4:0];
  wire        panel_run_key = pins[5];
  wire        panel_stop_key = pins[6];
  wire        multifunction_key_hold = pins[7];
  wire        output_freq_zero, dc_brake_done, speed_matched, drive_output_enable;
  wire        run_forward, run_reverse, jog_active, dc_brake_active, speed_track_active;
  wire        decel_active, run_indicator, source_lamp, comm_timeout_flag, timed_stop_flag;
  wire        reverse_blocked, aux_selected;
  wire [1:0]  source_indicator;
  wire [3:0]  main_ref_channel;
  wire [15:0] target_freq;
  integer     error_cnt = 0;
  integer     comparisons = 0;
  integer     cycles = 0;

  drive_run_command_select #(.TICK_CYCLES(TICK)) drive_run_command_select_i (.*);
  drive_plant_model drive_plant_model_i (.*);

  initial forever #12.5 mclk = ~mclk;

  task close_out;
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Timed stop minute plus margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task w(input integer n);
    repeat (n) @(posedge mclk);
  endtask

  task look(input integer n);
    w(n);
    @(negedge mclk);
  endtask

  task pulse(input integer i);
    w(1);
    pins[i] <= 1'b1;
    w(2);
    pins[i] <= 1'b0;
  endtask

  task t_panel;
    pulse(5);
    look(3);
    chk("fwd", run_forward, 1'b1);
    pulse(6);
    look(1);
    chk("decel", decel_active, 1'b1);
    chk("lamp", run_indicator, 1'b0);
    look(12);
    w(1);
    pins[7] <= 1'b1;
    look(4);
    chk("jog", jog_active, 1'b1);
    w(1);
    pins[7] <= 1'b0;
    look(2);
    chk("decel", decel_active, 1'b1);
    look(12);
  endtask

  task t_reverse;
    w(1);
    direction_invert <= 1'b1;
    reverse_inhibit <= 1'b1;
    pulse(5);
    look(3);
    chk("blocked", reverse_blocked, 1'b1);
    pulse(6);
    reverse_inhibit <= 1'b0;
    stop_mode_select <= 1'b1;
    pulse(5);
    look(3);
    chk("rev", run_reverse, 1'b1);
    pulse(6);
    look(1);
    chk("oen", drive_output_enable, 1'b0);
    w(1);
    direction_invert <= 1'b0;
    stop_mode_select <= 1'b0;
  endtask

  task t_terminal;
    integer i;
    w(1);
    command_source_select <= `SRC_TERMINAL;
    for (i = 0; i < 4; i = i + 1) begin
      w(1);
      pins[1:0] <= 2'(8'h2D >> (2 * i));
      look(12);
      chk("fwd", run_forward, pins[1:0] == 2'h1);
      chk("rev", run_reverse, pins[1:0] == 2'h2);
    end
    pulse(5);
    look(3);
    chk("lamp", run_indicator, 1'b0);
    w(1);
    switch_signal_mode <= `SW_THREE_WIRE;
    pins[2] <= 1'b1;
    pulse(0);
    look(3);
    chk("fwd", run_forward, 1'b1);
    pulse(1);
    look(14);
    chk("rev", run_reverse, 1'b1);
    w(1);
    pins[2] <= 1'b0;
    look(2);
    chk("lamp", run_indicator, 1'b0);
    look(12);
  endtask

  task t_auto;
    w(1);
    switch_signal_mode <= `SW_TWO_WIRE;
    timed_stop_enable <= 1'b1;
    pins[0] <= 1'b1;
    look(`TICKS_PER_MIN * TICK + 40);
    chk("timed", timed_stop_flag, 1'b0);
    w(1);
    timed_stop_duration <= 16'h0001;
    look(30);
    chk("timed", timed_stop_flag, 1'b1);
    w(1);
    pins[0] <= 1'b0;
    command_source_select <= `SRC_COMM;
    comm_timeout_setting <= 8'h03;
    w(1);
    comm_cmd <= `CC_FWD_RUN;
    comm_cmd_valid <= 1'b1;
    comm_frame_ok <= 1'b1;
    w(1);
    comm_cmd_valid <= 1'b0;
    comm_frame_ok <= 1'b0;
    look(3);
    chk("fwd", run_forward, 1'b1);
    chk("ind", source_indicator, `IND_BLINK);
    chk("freq", target_freq, 16'h0003);
    look(4 * TICK + 20);
    chk("silence", comm_timeout_flag, 1'b1);
    chk("fwd", run_forward, 1'b0);
  endtask

  initial begin
    w(3);
    reset_n <= 1'b1;
    w(1);
    t_panel;
    t_reverse;
    t_terminal;
    t_auto;
    close_out;
  end
endmodule
